//--- core/capture_compare_timer.v
// Dual width capture/compare timer with an AXI4-Lite register slave
// Assumes one clock; the pin input is asynchronous
//
// What this block does
// - Counter steps on prescaler selected count clock
// - Control register enables counting, picks width
// - Reset clears counter, counting stays stopped
// - Counter readable only, width follows mode
// - Primary compare match raises first interrupt
// - Primary match triggers output, optionally clears
// - Primary compare readable, writable, width follows
// - Second register is compare or capture
// - Compare mode match interrupts, triggers, clears
// - Capture mode latches counter on edges
// - Minimum pulse width follows sampling clock
// - External mode counts one or both edges
// - Resolution from oscillator/8 to oscillator/2048
// - Enable from zero clears on first tick
// - Wrap sets overflow, software clears it
// - Match or capture clears on next tick
// - Capture register latches edges, resets zero
`timescale 1ns/1ps
`include "timer_regs.vh"

module capture_compare_timer (
	input wire clk,
	input wire nrst,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_edge_input,
	output reg compare0_irq,
	output reg compare1_irq,
	output reg rto_trigger
);

// ==========================================================
// Registers
reg [15:0] up_counter_reg;
reg [15:0] up_counter_next;
reg [15:0] primary_compare_reg;
reg [15:0] capture_compare_reg;
reg [15:0] capture_reg;
reg [7:0] counter_control_reg;
reg [3:0] prescale_select_reg;
reg [7:0] capture_compare_control_reg;
reg [1:0] sampling_clock_select_reg;
reg overflow_flag_reg;
reg first_tick_reg;
reg clear_pend_reg;
reg [11:0] awaddr_reg;
reg aw_held_reg;
reg [31:0] wdata_reg;
reg [3:0] wstrb_reg;
reg w_held_reg;

wire count_tick;
wire int_tick;
wire edge_pulse;
wire enable;
wire wide;
wire capture_mode;
wire ext_mode;
wire [15:0] mask;
wire match0;
wire match1;
wire wrap;
wire do_write;
wire ovf_clear;

assign enable = counter_control_reg[`CTL_ENABLE_BIT];
assign wide = counter_control_reg[`CTL_WIDTH_BIT];
assign capture_mode = capture_compare_control_reg[`CC_CAPTURE_BIT];
assign ext_mode = (prescale_select_reg == `PRESCALE_EXT);
assign mask = wide ? 16'hFFFF : 16'h00FF;

// Byte lane merge for a 16 bit register
function [15:0] merge16;
	input [15:0] old;
	input [31:0] data;
	input [3:0] strb;
	begin
		merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
		merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
	end
endfunction

// ==========================================================
// Count clock sources
prescaler #(
	.DIV_W(12)
) u_prescaler (
	.clk(clk),
	.nrst(nrst),
	.sel(prescale_select_reg),
	.run(enable),
	.tick(int_tick)
);

edge_detect u_edge (
	.clk(clk),
	.nrst(nrst),
	.pin(ext_edge_input),
	.sample_sel(sampling_clock_select_reg),
	.both_edges(capture_compare_control_reg[`CC_BOTH_EDGE_BIT]),
	.falling(capture_compare_control_reg[`CC_FALL_BIT]),
	.edge_pulse(edge_pulse)
);

// External mode counts edges, else prescaled ticks
assign count_tick = enable & (ext_mode ? edge_pulse : int_tick);
assign wrap = ((up_counter_reg & mask) == mask) & count_tick;

// Matches seen only as the counter steps, masked to width
assign match0 = enable & count_tick & ~first_tick_reg &
	(((up_counter_next ^ primary_compare_reg) & mask) == 16'h0000);
assign match1 = enable & count_tick & ~first_tick_reg & ~capture_mode &
	(((up_counter_next ^ capture_compare_reg) & mask) == 16'h0000);

// ==========================================================
// Next counter value
always @* begin
	if (first_tick_reg || clear_pend_reg)
		up_counter_next = 16'h0000;
	else
		up_counter_next = (up_counter_reg + 16'h0001) & mask;
end

// ==========================================================
// Counter, clear pending, capture and event outputs
always @(posedge clk) begin
	if (!nrst) begin
		up_counter_reg <= `RST_COUNT;
		first_tick_reg <= 1'b0;
		clear_pend_reg <= 1'b0;
		capture_reg <= 16'h0000;
		compare0_irq <= 1'b0;
		compare1_irq <= 1'b0;
		rto_trigger <= 1'b0;
		overflow_flag_reg <= 1'b0;
	end else begin
		compare0_irq <= match0;
		compare1_irq <= match1;
		rto_trigger <= match0 | match1;
		if (!enable) begin
			up_counter_reg <= 16'h0000;
			first_tick_reg <= 1'b1;
			clear_pend_reg <= 1'b0;
		end else if (count_tick) begin
			up_counter_reg <= up_counter_next;
			first_tick_reg <= 1'b0;
			clear_pend_reg <=
				(match0 & capture_compare_control_reg[`CC_CLR0_BIT]) |
				(match1 & capture_compare_control_reg[`CC_CLR1_BIT]);
		end
		// Capture on edge; clear request waits for next tick
		if (enable && edge_pulse) begin
			capture_reg <= up_counter_reg & mask;
			if (capture_mode &&
				capture_compare_control_reg[`CC_CLRCAP_BIT])
				clear_pend_reg <= 1'b1;
		end
		// Hardware set wins over software clear
		if (wrap && !first_tick_reg && !clear_pend_reg)
			overflow_flag_reg <= 1'b1;
		else if (ovf_clear)
			overflow_flag_reg <= 1'b0;
	end
end

// ==========================================================
// AXI write channel holding
assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
assign do_write = aw_held_reg & w_held_reg;
assign ovf_clear = do_write & (awaddr_reg == `OFS_STATUS) &
	wstrb_reg[0] & wdata_reg[`ST_OVF_BIT];

always @(posedge clk) begin
	if (!nrst) begin
		aw_held_reg <= 1'b0;
		w_held_reg <= 1'b0;
		awaddr_reg <= 12'h000;
		wdata_reg <= 32'h00000000;
		wstrb_reg <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			if (awaddr_reg == `OFS_COUNT_VALUE ||
				awaddr_reg > `OFS_STATUS)
				s_axi_bresp <= 2'h2;
			else
				s_axi_bresp <= 2'h0;
		end else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end
end

// ==========================================================
// Register writes
always @(posedge clk) begin
	if (!nrst) begin
		counter_control_reg <= `RST_CONTROL;
		prescale_select_reg <= `RST_PRESCALE;
		capture_compare_control_reg <= `RST_CC_CONTROL;
		sampling_clock_select_reg <= `RST_SAMPLING;
		primary_compare_reg <= 16'h0000;
		capture_compare_reg <= 16'h0000;
	end else begin
		if (do_write && wstrb_reg[0]) begin
			if (awaddr_reg == `OFS_COUNTER_CONTROL)
				counter_control_reg <= wdata_reg[7:0];
			else if (awaddr_reg == `OFS_PRESCALE_SELECT)
				prescale_select_reg <= wdata_reg[3:0];
			else if (awaddr_reg == `OFS_CC_CONTROL)
				capture_compare_control_reg <= wdata_reg[7:0];
			else if (awaddr_reg == `OFS_SAMPLING_SELECT)
				sampling_clock_select_reg <= wdata_reg[1:0];
		end
		if (do_write && awaddr_reg == `OFS_INTERVAL_COMPARE)
			primary_compare_reg <= merge16(primary_compare_reg,
				wdata_reg, wstrb_reg);
		// Capture in capture mode overrides a software write
		if (capture_mode && enable && edge_pulse)
			capture_compare_reg <= up_counter_reg & mask;
		else if (do_write && awaddr_reg == `OFS_CAPTURE_OR_COMPARE)
			capture_compare_reg <= merge16(capture_compare_reg,
				wdata_reg, wstrb_reg);
	end
end

// ==========================================================
// AXI read channel, one cycle answer
assign s_axi_arready = ~s_axi_rvalid;

always @(posedge clk) begin
	if (!nrst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'h0;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= 2'h0;
		if (s_axi_araddr[11:2] == `OFS_COUNT_VALUE >> 2)
			s_axi_rdata <= {16'h0000, up_counter_reg & mask};
		else if (s_axi_araddr[11:2] == `OFS_INTERVAL_COMPARE >> 2)
			s_axi_rdata <= {16'h0000, primary_compare_reg & mask};
		else if (s_axi_araddr[11:2] == `OFS_CAPTURE_OR_COMPARE >> 2)
			s_axi_rdata <= {16'h0000, capture_compare_reg & mask};
		else if (s_axi_araddr[11:2] == `OFS_CAPTURE >> 2)
			s_axi_rdata <= {16'h0000, capture_reg & mask};
		else if (s_axi_araddr[11:2] == `OFS_COUNTER_CONTROL >> 2)
			s_axi_rdata <= {24'h000000, counter_control_reg};
		else if (s_axi_araddr[11:2] == `OFS_PRESCALE_SELECT >> 2)
			s_axi_rdata <= {28'h0000000, prescale_select_reg};
		else if (s_axi_araddr[11:2] == `OFS_CC_CONTROL >> 2)
			s_axi_rdata <= {24'h000000, capture_compare_control_reg};
		else if (s_axi_araddr[11:2] == `OFS_SAMPLING_SELECT >> 2)
			s_axi_rdata <= {30'h00000000, sampling_clock_select_reg};
		else if (s_axi_araddr[11:2] == `OFS_STATUS >> 2)
			s_axi_rdata <= {31'h00000000, overflow_flag_reg};
		else begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h2;
		end
	end else if (s_axi_rvalid && s_axi_rready)
		s_axi_rvalid <= 1'b0;
end

endmodule // capture_compare_timer

//--- core/edge_detect.v
// Synchroniser, sampled noise filter and edge detector for the input pin
// Assumes pin is asynchronous to clk
`timescale 1ns/1ps
`include "timer_regs.vh"

module edge_detect (
	input wire clk,
	input wire nrst,
	input wire pin,
	input wire [1:0] sample_sel,
	input wire both_edges,
	input wire falling,
	output reg edge_pulse
);

reg sync1_reg;
reg sync2_reg;
reg [7:0] samp_reg;
reg [2:0] cnt_reg;
reg level_reg;
wire samp_tick;

// Sampling strobe: every clock, or every 64, 128 or 256 clocks
assign samp_tick = (sample_sel == 2'h0) ? 1'b1 :
	(sample_sel == 2'h1) ? (samp_reg[5:0] == 6'h00) :
	(sample_sel == 2'h2) ? (samp_reg[6:0] == 7'h00) :
	(samp_reg[7:0] == 8'h00);

// ==========================================================
// Two flop synchroniser, level held stable four samples
always @(posedge clk) begin
	if (!nrst) begin
		sync1_reg <= 1'b0;
		sync2_reg <= 1'b0;
		samp_reg <= 8'h00;
		cnt_reg <= 3'h0;
		level_reg <= 1'b0;
		edge_pulse <= 1'b0;
	end else begin
		sync1_reg <= pin;
		sync2_reg <= sync1_reg;
		samp_reg <= samp_reg + 8'h01;
		edge_pulse <= 1'b0;
		if (samp_tick) begin
			if (sync2_reg == level_reg)
				cnt_reg <= 3'h0;
			else if (cnt_reg == `EDGE_STABLE_SAMPLES - 1) begin
				cnt_reg <= 3'h0;
				level_reg <= sync2_reg;
				edge_pulse <= both_edges | (sync2_reg ^ falling);
			end else
				cnt_reg <= cnt_reg + 3'h1;
		end
	end
end

endmodule // edge_detect

//--- core/prescaler.v
// Free running divider giving the internal count clock strobe
// Assumes the system clock stands in for the oscillator
`timescale 1ns/1ps
`include "timer_regs.vh"

module prescaler #(
	parameter DIV_W = 12
) (
	input wire clk,
	input wire nrst,
	input wire [3:0] sel,
	input wire run,
	output reg tick
);

reg [DIV_W-1:0] div_reg;
wire [DIV_W-1:0] div_next;
wire [DIV_W-1:0] one_val;
reg [3:0] shift;

// Selection to exponent, clamped to oscillator/1024 above PRESCALE_MAX
always @* begin
	if (sel > `PRESCALE_MAX)
		shift = 4'hA;
	else
		shift = sel + 4'h3;
end

// Constant one at the divider's own width
assign one_val = {{(DIV_W-1){1'b0}}, 1'b1};
assign div_next = div_reg + one_val;

// ==========================================================
// Divider restarts while stopped
always @(posedge clk) begin
	if (!nrst || !run) begin
		div_reg <= {DIV_W{1'b0}};
		tick <= 1'b0;
	end else begin
		div_reg <= div_next;
		tick <= (div_next & ((one_val << shift) - one_val)) ==
			{DIV_W{1'b0}};
	end
end

endmodule // prescaler

//--- core/timer_regs.vh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the timer core and its helper modules
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// ==========================================================
// Register byte offsets
`define OFS_COUNT_VALUE 12'h000
`define OFS_INTERVAL_COMPARE 12'h004
`define OFS_CAPTURE_OR_COMPARE 12'h008
`define OFS_CAPTURE 12'h00C
`define OFS_COUNTER_CONTROL 12'h010
`define OFS_PRESCALE_SELECT 12'h014
`define OFS_CC_CONTROL 12'h018
`define OFS_SAMPLING_SELECT 12'h01C
`define OFS_STATUS 12'h020

// ==========================================================
// Field positions
`define CTL_WIDTH_BIT 0
`define CTL_ENABLE_BIT 3
`define CC_CAPTURE_BIT 0
`define CC_CLR0_BIT 1
`define CC_CLR1_BIT 2
`define CC_CLRCAP_BIT 3
`define CC_BOTH_EDGE_BIT 4
`define CC_FALL_BIT 5
`define ST_OVF_BIT 0

// ==========================================================
// Reset values
`define RST_CONTROL 8'h00
`define RST_PRESCALE 4'h1
`define RST_CC_CONTROL 8'h00
`define RST_SAMPLING 2'h0
`define RST_COUNT 16'h0000

// ==========================================================
// Prescale selections (oscillator divided by 2^(sel+3)), edge filter sample count
`define PRESCALE_EXT 4'hF
`define PRESCALE_MAX 4'h8
`define EDGE_STABLE_SAMPLES 4

`endif

//--- testbench/pulse_source.sv
// Pulse source on the edge detected input pin
// Assumes go is raised for one cycle with count already set
`timescale 1ns/1ps

module pulse_source #(
	parameter int HALF = 10
) (
	input wire logic clk,
	input wire logic go,
	input wire logic [9:0] count,
	output logic pin,
	output logic busy
);
	// Square pulses, each level held HALF clocks, pin idles low
	initial begin
		pin = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				busy <= 1'b1;
				// Levels well above four samples, rate below clk/8
				repeat (count) begin
					pin <= 1'b1;
					repeat (HALF) @(posedge clk);
					pin <= 1'b0;
					repeat (HALF) @(posedge clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule // pulse_source

//--- testbench/tb_top.sv
// Self-checking bench of the capture/compare timer
// Assumes a bound checker and the pulse source beside the design
`timescale 1ns/1ps

module tb_top;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [1:0] s;} row_t;
	logic clk = 1'b0, nrst = 1'b0, go = 1'b0;
	logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
	logic [31:0] w_data = 32'h0, r_data, rd, cap;
	logic [3:0] w_strb = 4'hF;
	logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
	logic ar_valid = 1'b0, r_ready = 1'b0;
	logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic pin, irq0, irq1, rto, busy;
	logic [1:0] b_resp, r_resp, rs;
	logic [9:0] n_pulse = 10'h000;
	int mismatches = 0, checked = 0, n0 = 0, n1 = 0, nr = 0, slow = 0;
	row_t rows [17] = '{
		'{0, 12'h000, 32'h0, 2'h0}, '{0, 12'h00C, 32'h0, 2'h0},
		'{0, 12'h010, 32'h0, 2'h0}, '{0, 12'h014, 32'h1, 2'h0},
		'{0, 12'h018, 32'h0, 2'h0}, '{0, 12'h01C, 32'h0, 2'h0},
		'{0, 12'h020, 32'h0, 2'h0}, '{0, 12'h024, 32'h0, 2'h2},
		'{1, 12'h000, 32'h5, 2'h2}, '{0, 12'h000, 32'h0, 2'h0},
		'{1, 12'h004, 32'h1234, 2'h0}, '{0, 12'h004, 32'h34, 2'h0},
		'{1, 12'h008, 32'hABCD, 2'h0}, '{0, 12'h008, 32'hCD, 2'h0},
		'{1, 12'h010, 32'h1, 2'h0}, '{0, 12'h004, 32'h1234, 2'h0},
		'{0, 12'h008, 32'hABCD, 2'h0}};

	// ==========================================================
	// Clock, design and far side
	initial begin
		forever #10 clk = ~clk;
	end

	capture_compare_timer dut (.clk(clk), .nrst(nrst),
		.s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
		.s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb),
		.s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
		.s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
		.s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
		.s_axi_rready(r_ready), .ext_edge_input(pin), .compare0_irq(irq0),
		.compare1_irq(irq1), .rto_trigger(rto));

	pulse_source src (.clk(clk), .go(go), .count(n_pulse), .pin(pin),
		.busy(busy));

	// Event pulse counters
	always @(posedge clk) begin
		if (irq0 === 1'b1) n0++;
		if (irq1 === 1'b1) n1++;
		if (rto === 1'b1) nr++;
	end

	// ==========================================================
	// Tasks
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task end_of_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task rst;
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		aw_addr <= a; w_data <= d; aw_valid <= 1'b1; w_valid <= 1'b1;
		b_ready <= (slow == 0);
		do begin
			@(posedge clk); k++;
			if (aw_valid && aw_ready) aw_valid <= 1'b0;
			if (w_valid && w_ready) w_valid <= 1'b0;
			if (k == slow) b_ready <= 1'b1;
		end while (!(b_valid && b_ready) && k < 50);
		rs = b_resp; b_ready <= 1'b0;
		if (k >= 50) mismatches++;
		@(posedge clk);
	endtask

	task rdr(input logic [11:0] a);
		int k;
		k = 0;
		ar_addr <= a; ar_valid <= 1'b1; r_ready <= (slow == 0);
		do begin
			@(posedge clk); k++;
			if (ar_valid && ar_ready) ar_valid <= 1'b0;
			if (k == slow) r_ready <= 1'b1;
		end while (!(r_valid && r_ready) && k < 50);
		rd = r_data; rs = r_resp; r_ready <= 1'b0;
		if (k >= 50) mismatches++;
		@(posedge clk);
	endtask

	// Send n pulses, then let sync and filter settle
	task pulses(input int n);
		int k;
		k = 0;
		n_pulse <= n[9:0]; go <= 1'b1;
		@(posedge clk); go <= 1'b0;
		@(posedge clk);
		while (busy && k < 6000) begin @(posedge clk); k++; end
		repeat (12) @(posedge clk);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		rst;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
				chk("bresp", rs, rows[i].s);
			end else begin
				rdr(rows[i].a);
				chk("rdata", rd, rows[i].d);
				chk("rresp", rs, rows[i].s);
			end
		end
		$display("register table done");
		// Late ready from the master, answers must stand
		slow = 3;
		wr(12'h004, 32'h4321); chk("bresp", rs, 32'h0);
		rdr(12'h004); chk("slow read", rd, 32'h4321);
		slow = 0;
		$display("slow handshake done");
		// Counter counts rising pin edges in external mode
		wr(12'h014, 32'hF); wr(12'h010, 32'h9); pulses(5);
		rdr(12'h000); chk("count", rd, 32'h4);
		wr(12'h010, 32'h9); pulses(2);
		rdr(12'h000); chk("count", rd, 32'h6);
		wr(12'h010, 32'h0);
		rdr(12'h000); chk("count", rd, 32'h0);
		$display("event count done");
		// Short pulses rejected by slow sampling, then both edges
		wr(12'h01C, 32'h1); wr(12'h010, 32'h9); pulses(3);
		rdr(12'h000); chk("filtered", rd, 32'h0);
		wr(12'h010, 32'h0); wr(12'h01C, 32'h0); wr(12'h018, 32'h10);
		wr(12'h010, 32'h9); pulses(2);
		rdr(12'h000); chk("both edges", rd, 32'h3);
		wr(12'h010, 32'h0);
		$display("edge filter done");
		wr(12'h004, 32'h3); wr(12'h018, 32'h2);
		n0 = 0; n1 = 0; nr = 0;
		wr(12'h010, 32'h9); pulses(8);
		rdr(12'h000); chk("count", rd, 32'h3);
		chk("irq0", n0, 32'h2);
		chk("trigger", nr, 32'h2);
		chk("irq1", n1, 32'h0);
		$display("compare clear done");
		wr(12'h010, 32'h0); wr(12'h018, 32'h0);
		wr(12'h004, 32'h1F0); wr(12'h008, 32'h105);
		n0 = 0; n1 = 0; nr = 0;
		wr(12'h010, 32'h8); pulses(257);
		rdr(12'h000); chk("count", rd, 32'h0);
		rdr(12'h020); chk("overflow", rd, 32'h1);
		chk("irq0", n0, 32'h1);
		chk("irq1", n1, 32'h1);
		wr(12'h020, 32'h1);
		rdr(12'h020); chk("overflow", rd, 32'h0);
		$display("eight bit wrap done");
		wr(12'h010, 32'h0); wr(12'h018, 32'h1); wr(12'h014, 32'h0);
		wr(12'h010, 32'h9);
		repeat (40) @(posedge clk);
		pulses(1);
		rdr(12'h008); cap = rd;
		rdr(12'h00C); chk("capture", rd, cap);
		chk("nonzero", cap != 32'h0, 32'h1);
		$display("capture done");
		rst;
		rdr(12'h000); chk("count", rd, 32'h0);
		rdr(12'h00C); chk("capture", rd, 32'h0);
		rdr(12'h010); chk("control", rd, 32'h0);
		$display("reset done");
		end_of_test;
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test;
	end
endmodule // tb_top

//--- testbench/timer_assertions.sv
// Checker of bus handshakes and event pulses of the timer
// Assumes binding onto capture_compare_timer, one clock domain
`timescale 1ns/1ps

module timer_checker (
	input logic clk,
	input logic nrst,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic compare0_irq,
	input logic compare1_irq,
	input logic rto_trigger
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_irq0_pulse; compare0_irq |=> !compare0_irq; endproperty
	a_irq0_pulse: assert property (p_irq0_pulse)
		else $error("first match pulse too long");
	property p_irq1_pulse; compare1_irq |=> !compare1_irq; endproperty
	a_irq1_pulse: assert property (p_irq1_pulse)
		else $error("second match pulse too long");
	property p_trigger; rto_trigger == (compare0_irq || compare1_irq);
	endproperty
	a_trigger: assert property (p_trigger)
		else $error("trigger not tied to matches");
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer late");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data not held");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write answer late");
	property p_wr_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write response not held");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_busy: assert property (p_busy)
		else $error("write taken while answering");
	property p_reset;
		disable iff (1'b0) !nrst |=> !s_axi_bvalid && !s_axi_rvalid
			&& !compare0_irq && !compare1_irq;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs active after reset");
endmodule // timer_checker

bind capture_compare_timer timer_checker chk_i (.clk(clk), .nrst(nrst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.compare0_irq(compare0_irq), .compare1_irq(compare1_irq),
	.rto_trigger(rto_trigger));
